//--- hdl/pie_defines.vh
// Offsets, field positions, reset values and masks of the peripheral enable banks
`ifndef PIE_DEFINES_VH
`define PIE_DEFINES_VH

// ==================================================
// Register offsets (byte address on the plain port)
// ==================================================
`define PIE_ADDR_W 8
`define PIE_OFF_ENABLE_TWO 8'h00
`define PIE_OFF_ENABLE_THREE 8'h01
`define PIE_OFF_FLAGS_TWO 8'h02
`define PIE_OFF_FLAGS_THREE 8'h03
`define PIE_OFF_STATUS 8'h04

// ==================================================
// Bank two field positions
// ==================================================
`define PIE_OSC_FAIL_BIT 7
`define PIE_COMPARATOR_TWO_BIT 6
`define PIE_COMPARATOR_ONE_BIT 5
`define PIE_NVM_WRITE_DONE_BIT 4
`define PIE_SERIAL_COLLISION_BIT 3
`define PIE_CAPCOMP_TWO_BIT 0

// ==================================================
// Bank three field positions
// ==================================================
`define PIE_CAPCOMP_FOUR_BIT 5
`define PIE_CAPCOMP_THREE_BIT 4
`define PIE_TIMER_SIX_MATCH_BIT 3
`define PIE_TIMER_FOUR_MATCH_BIT 1

// ==================================================
// Status register field positions
// ==================================================
`define PIE_STAT_REQ_BIT 0
`define PIE_STAT_IRQ_BIT 1
`define PIE_STAT_MASTER_BIT 2

// ==================================================
// Implemented bit masks and reset values
// ==================================================
`define PIE_IMPL_TWO_LARGE 8'hF9
`define PIE_IMPL_TWO_SMALL 8'hB9
`define PIE_IMPL_THREE 8'h3A
`define PIE_RESET_ENABLE 8'h00
`define PIE_RESET_FLAGS 8'h00
`define PIE_READ_ZERO 8'h00

`endif

//--- hdl/pie_enable_banks.v
// Peripheral interrupt enable banks two and three with their pending flags
//
// Added by the designer: the register addresses and the strobed register port.
`timescale 1ns/1ps
`default_nettype none
`include "pie_defines.vh"

// ==================================================
// Summary of operation
// ==================================================

module pie_enable_banks #(
   parameter LARGE_VARIANT = 1
) (
   // Clock and reset
   input wire clk_in,
   input wire resetn_in,
   // Register port
   input wire [7:0] addr_in,
   input wire [7:0] wdata_in,
   input wire wr_in,
   input wire rd_in,
   output wire [7:0] rdata_out,
   // Peripheral event pulses, bank two layout
   input wire [7:0] event_two_in,
   // Peripheral event pulses, bank three layout
   input wire [7:0] event_three_in,
   // Master enable from the core interrupt control register
   input wire peripheral_master_irq_en_in,
   // Requests toward the core
   output wire periph_req_out,
   output wire periph_irq_out
);

   // ==================================================
   // Implemented positions
   // ==================================================
   // On the small variant the second comparator does not exist, so its
   // enable and flag collapse to constant zero.
   localparam [7:0] IMPL_TWO = (LARGE_VARIANT != 0) ?
      `PIE_IMPL_TWO_LARGE : `PIE_IMPL_TWO_SMALL;
   localparam [7:0] IMPL_THREE = `PIE_IMPL_THREE;

   // ==================================================
   // State
   // ==================================================
   reg [7:0] enable_two_ff;
   reg [7:0] enable_three_ff;
   reg [7:0] flags_two_ff;
   reg [7:0] flags_three_ff;
   reg [7:0] rdata_ff;

   reg [7:0] nxt_enable_two;
   reg [7:0] nxt_enable_three;
   reg [7:0] nxt_rdata;

   wire [7:0] nxt_flags_two;
   wire [7:0] nxt_flags_three;

   // ==================================================
   // Address decode
   // ==================================================
   wire hit_enable_two;
   wire hit_enable_three;
   wire hit_flags_two;
   wire hit_flags_three;
   wire hit_status;

   assign hit_enable_two = (addr_in == `PIE_OFF_ENABLE_TWO);
   assign hit_enable_three = (addr_in == `PIE_OFF_ENABLE_THREE);
   assign hit_flags_two = (addr_in == `PIE_OFF_FLAGS_TWO);
   assign hit_flags_three = (addr_in == `PIE_OFF_FLAGS_THREE);
   assign hit_status = (addr_in == `PIE_OFF_STATUS);

   wire clr_two_en;
   wire clr_three_en;

   assign clr_two_en = wr_in & hit_flags_two;
   assign clr_three_en = wr_in & hit_flags_three;

   // ==================================================
   // Event and clear masks
   // ==================================================
   // Events on absent positions are dropped here, so a stray strobe
   // from a peripheral that is not fitted can never latch a flag.
   wire [7:0] ev_two_live;
   wire [7:0] ev_three_live;
   wire [7:0] clr_two_mask;
   wire [7:0] clr_three_mask;

   assign ev_two_live = event_two_in & IMPL_TWO;
   assign ev_three_live = event_three_in & IMPL_THREE;
   assign clr_two_mask = {8{clr_two_en}} & wdata_in;
   assign clr_three_mask = {8{clr_three_en}} & wdata_in;

   // ==================================================
   // Enable register write path
   // ==================================================
   always @* begin
      nxt_enable_two = enable_two_ff;
      nxt_enable_three = enable_three_ff;
      // Flag, status and unmapped offsets leave both enables alone;
      // flag clears are handled in the flag cells below.
      if (wr_in && hit_enable_two) begin
         // Only implemented positions take the written value
         nxt_enable_two = wdata_in & IMPL_TWO;
      end else if (wr_in && hit_enable_three) begin
         nxt_enable_three = wdata_in & IMPL_THREE;
      end
   end

   always @(posedge clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         // Every reset source reaches this one input, so power-on,
         // brown-out and the others all clear the enables alike.
         enable_two_ff <= `PIE_RESET_ENABLE;
         enable_three_ff <= `PIE_RESET_ENABLE;
      end else begin
         enable_two_ff <= nxt_enable_two;
         enable_three_ff <= nxt_enable_three;
      end
   end

   // ==================================================
   // Pending flags, one cell per bit
   // ==================================================
   // A flag is set by its event pulse whatever the enable holds; a
   // write of one clears it, but an event in the same cycle wins so
   // nothing is lost.
   genvar gi;
   generate
      for (gi = 0; gi < 8; gi = gi + 1) begin : g_flag
         assign nxt_flags_two[gi] = ev_two_live[gi] | (flags_two_ff[gi] & ~clr_two_mask[gi]);
         assign nxt_flags_three[gi] = ev_three_live[gi] | (flags_three_ff[gi] & ~clr_three_mask[gi]);
      end
   endgenerate

   always @(posedge clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         flags_two_ff <= `PIE_RESET_FLAGS;
         flags_three_ff <= `PIE_RESET_FLAGS;
      end else begin
         flags_two_ff <= nxt_flags_two;
         flags_three_ff <= nxt_flags_three;
      end
   end

   // ==================================================
   // Named enable fields
   // ==================================================
   // Each enable by its own name, so the request gating below reads
   // as the register layout does rather than by bit index.
   wire osc_fail_irq_en;
   wire comparator_two_irq_en;
   wire comparator_one_irq_en;
   wire nvm_write_done_irq_en;
   wire serial_collision_irq_en;
   wire capcomp_two_irq_en;
   wire capcomp_four_irq_en;
   wire capcomp_three_irq_en;
   wire timer_six_match_irq_en;
   wire timer_four_match_irq_en;

   assign osc_fail_irq_en = enable_two_ff[`PIE_OSC_FAIL_BIT];
   assign comparator_two_irq_en = enable_two_ff[`PIE_COMPARATOR_TWO_BIT];
   assign comparator_one_irq_en = enable_two_ff[`PIE_COMPARATOR_ONE_BIT];
   assign nvm_write_done_irq_en = enable_two_ff[`PIE_NVM_WRITE_DONE_BIT];
   assign serial_collision_irq_en = enable_two_ff[`PIE_SERIAL_COLLISION_BIT];
   assign capcomp_two_irq_en = enable_two_ff[`PIE_CAPCOMP_TWO_BIT];
   assign capcomp_four_irq_en = enable_three_ff[`PIE_CAPCOMP_FOUR_BIT];
   assign capcomp_three_irq_en = enable_three_ff[`PIE_CAPCOMP_THREE_BIT];
   assign timer_six_match_irq_en = enable_three_ff[`PIE_TIMER_SIX_MATCH_BIT];
   assign timer_four_match_irq_en = enable_three_ff[`PIE_TIMER_FOUR_MATCH_BIT];

   // ==================================================
   // Named pending flags
   // ==================================================
   // Absent positions never latch, so the names need no mask here.
   wire osc_fail_pending;
   wire comparator_two_pending;
   wire comparator_one_pending;
   wire nvm_write_done_pending;
   wire serial_collision_pending;
   wire capcomp_two_pending;
   wire capcomp_four_pending;
   wire capcomp_three_pending;
   wire timer_six_match_pending;
   wire timer_four_match_pending;

   assign osc_fail_pending = flags_two_ff[`PIE_OSC_FAIL_BIT];
   assign comparator_two_pending = flags_two_ff[`PIE_COMPARATOR_TWO_BIT];
   assign comparator_one_pending = flags_two_ff[`PIE_COMPARATOR_ONE_BIT];
   assign nvm_write_done_pending = flags_two_ff[`PIE_NVM_WRITE_DONE_BIT];
   assign serial_collision_pending = flags_two_ff[`PIE_SERIAL_COLLISION_BIT];
   assign capcomp_two_pending = flags_two_ff[`PIE_CAPCOMP_TWO_BIT];
   assign capcomp_four_pending = flags_three_ff[`PIE_CAPCOMP_FOUR_BIT];
   assign capcomp_three_pending = flags_three_ff[`PIE_CAPCOMP_THREE_BIT];
   assign timer_six_match_pending = flags_three_ff[`PIE_TIMER_SIX_MATCH_BIT];
   assign timer_four_match_pending = flags_three_ff[`PIE_TIMER_FOUR_MATCH_BIT];

   // ==================================================
   // Request combining
   // ==================================================
   wire [7:0] gated_two;
   wire [7:0] gated_three;
   wire any_req;
   wire req_two;
   wire req_three;

   // Bank two layout: osc fail 7, comparator two 6, comparator one 5,
   // nvm write done 4, serial collision 3, capture compare two 0.
   assign gated_two[`PIE_OSC_FAIL_BIT] =
      osc_fail_pending & osc_fail_irq_en;
   assign gated_two[`PIE_COMPARATOR_TWO_BIT] =
      comparator_two_pending & comparator_two_irq_en;
   assign gated_two[`PIE_COMPARATOR_ONE_BIT] =
      comparator_one_pending & comparator_one_irq_en;
   assign gated_two[`PIE_NVM_WRITE_DONE_BIT] =
      nvm_write_done_pending & nvm_write_done_irq_en;
   assign gated_two[`PIE_SERIAL_COLLISION_BIT] =
      serial_collision_pending & serial_collision_irq_en;
   assign gated_two[2:1] = 2'h0;
   assign gated_two[`PIE_CAPCOMP_TWO_BIT] =
      capcomp_two_pending & capcomp_two_irq_en;

   // Bank three layout: capture compare four 5 and three 4,
   // timer six match 3, timer four match 1.
   assign gated_three[7:6] = 2'h0;
   assign gated_three[`PIE_CAPCOMP_FOUR_BIT] =
      capcomp_four_pending & capcomp_four_irq_en;
   assign gated_three[`PIE_CAPCOMP_THREE_BIT] =
      capcomp_three_pending & capcomp_three_irq_en;
   assign gated_three[`PIE_TIMER_SIX_MATCH_BIT] =
      timer_six_match_pending & timer_six_match_irq_en;
   assign gated_three[2] = 1'b0;
   assign gated_three[`PIE_TIMER_FOUR_MATCH_BIT] =
      timer_four_match_pending & timer_four_match_irq_en;
   assign gated_three[0] = 1'b0;

   // Per-bank ORs keep the final gate toward the core shallow
   assign req_two = |gated_two;
   assign req_three = |gated_three;
   assign any_req = req_two | req_three;

   // Combinational from flops so the core sees a new flag next cycle
   assign periph_req_out = any_req;
   assign periph_irq_out = any_req & peripheral_master_irq_en_in;

   // ==================================================
   // Read path
   // ==================================================
   wire [7:0] status_word;

   // Status is read-only; it shows the raw request, the gated request
   // and the master enable as the core sees them this cycle.
   assign status_word[7:3] = 5'h00;
   assign status_word[`PIE_STAT_MASTER_BIT] = peripheral_master_irq_en_in;
   assign status_word[`PIE_STAT_IRQ_BIT] = periph_irq_out;
   assign status_word[`PIE_STAT_REQ_BIT] = any_req;

   // Data stand for exactly one cycle after the read strobe and are
   // zero otherwise, which keeps an OR-ed read bus in the core clean.
   always @* begin
      nxt_rdata = `PIE_READ_ZERO;
      if (rd_in) begin
         if (hit_enable_two) begin
            nxt_rdata = enable_two_ff & IMPL_TWO;
         end else if (hit_enable_three) begin
            nxt_rdata = enable_three_ff & IMPL_THREE;
         end else if (hit_flags_two) begin
            nxt_rdata = flags_two_ff;
         end else if (hit_flags_three) begin
            nxt_rdata = flags_three_ff;
         end else if (hit_status) begin
            nxt_rdata = status_word;
         end else begin
            nxt_rdata = `PIE_READ_ZERO;
         end
      end
   end

   always @(posedge clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         rdata_ff <= `PIE_READ_ZERO;
      end else begin
         rdata_ff <= nxt_rdata;
      end
   end

   assign rdata_out = rdata_ff;

endmodule // pie_enable_banks

`default_nettype wire

//--- verification/pie_enable_banks_assertions.sv
// Port assertions for the peripheral interrupt enable banks
`timescale 1ns/1ps
`default_nettype none
`include "pie_defines.vh"
module pie_enable_banks_assertions #(
   parameter LARGE_VARIANT = 1
) (
   input wire logic clk_in,
   input wire logic resetn_in,
   input wire logic [7:0] addr_in,
   input wire logic [7:0] wdata_in,
   input wire logic wr_in,
   input wire logic rd_in,
   input wire logic [7:0] rdata_out,
   input wire logic [7:0] event_two_in,
   input wire logic [7:0] event_three_in,
   input wire logic peripheral_master_irq_en_in,
   input wire logic periph_req_out,
   input wire logic periph_irq_out
);
   localparam logic [7:0] IMPL_TWO = LARGE_VARIANT ? `PIE_IMPL_TWO_LARGE : `PIE_IMPL_TWO_SMALL;
   logic [7:0] en_two_ff;
   logic [7:0] en_three_ff;
   default clocking cb @(posedge clk_in); endclocking
   default disable iff (!resetn_in);
   sequence rd_of(logic [7:0] a);
      rd_in && addr_in == a;
   endsequence
   // ==================================================
   // Shadow enables: ties the request back to what software wrote
   always @(posedge clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         en_two_ff <= 8'h00;
         en_three_ff <= 8'h00;
      end else if (wr_in && addr_in == `PIE_OFF_ENABLE_TWO) begin
         en_two_ff <= wdata_in & IMPL_TWO;
      end else if (wr_in && addr_in == `PIE_OFF_ENABLE_THREE) begin
         en_three_ff <= wdata_in & `PIE_IMPL_THREE;
      end
   end
   // ==================================================
   // Checks
   irq_master_gate_a: assert property (periph_irq_out == (periph_req_out && peripheral_master_irq_en_in))
      else $error("irq not gated by master");
   read_idle_zero_a: assert property (!$past(rd_in) |-> rdata_out == 8'h00)
      else $error("read data outside read slot");
   two_readback_a: assert property (rd_of(`PIE_OFF_ENABLE_TWO) |=> rdata_out == en_two_ff)
      else $error("bank two readback");
   three_readback_a: assert property (rd_of(`PIE_OFF_ENABLE_THREE) |=> rdata_out == en_three_ff)
      else $error("bank three readback");
   event_request_a: assert property (|{event_two_in & en_two_ff, event_three_in & en_three_ff} && !wr_in |=> periph_req_out)
      else $error("enabled event gave no request");
   no_enable_quiet_a: assert property (en_two_ff == 8'h00 && en_three_ff == 8'h00 |-> !periph_req_out)
      else $error("request with all enables clear");
   status_bits_a: assert property (rd_of(`PIE_OFF_STATUS) |=> rdata_out[2:0] ==
      {$past(peripheral_master_irq_en_in), $past(periph_irq_out), $past(periph_req_out)})
      else $error("status bits wrong");
   unmapped_read_a: assert property (rd_in && addr_in > `PIE_OFF_STATUS |=> rdata_out == 8'h00)
      else $error("unmapped read not zero");
endmodule // pie_enable_banks_assertions
bind pie_enable_banks pie_enable_banks_assertions #(.LARGE_VARIANT(LARGE_VARIANT)) i_pie_chk (
   .clk_in(clk_in), .resetn_in(resetn_in), .addr_in(addr_in), .wdata_in(wdata_in), .wr_in(wr_in),
   .rd_in(rd_in), .rdata_out(rdata_out), .event_two_in(event_two_in), .event_three_in(event_three_in),
   .peripheral_master_irq_en_in(peripheral_master_irq_en_in), .periph_req_out(periph_req_out),
   .periph_irq_out(periph_irq_out));
`default_nettype wire

//--- verification/pie_enable_banks_bench.sv
// Self-checking bench for the peripheral interrupt enable banks
`timescale 1ns/1ps
`default_nettype none
`include "pie_defines.vh"
module pie_enable_banks_bench;
   logic clk_in = 1'b0, resetn_in = 1'b0, wr_in = 1'b0, rd_in = 1'b0, mst = 1'b0;
   logic [7:0] addr_in = 8'h00, wdata_in = 8'h00, ev2 = 8'h00, ev3 = 8'h00;
   wire [7:0] rdata_out;
   wire req, irq;
   wire [7:0] rdata_small;
   wire req_small;
   int n_mismatch = 0, samples_checked = 0, cycles = 0;
   always #12.5 clk_in = ~clk_in;
   pie_enable_banks i_pie_enable_banks (.clk_in(clk_in), .resetn_in(resetn_in), .addr_in(addr_in),
      .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in), .rdata_out(rdata_out), .event_two_in(ev2),
      .event_three_in(ev3), .peripheral_master_irq_en_in(mst), .periph_req_out(req), .periph_irq_out(irq));
   // Small variant: second comparator absent
   pie_enable_banks #(.LARGE_VARIANT(0)) i_pie_enable_banks_small (.clk_in(clk_in), .resetn_in(resetn_in),
      .addr_in(addr_in), .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in), .rdata_out(rdata_small),
      .event_two_in(ev2), .event_three_in(ev3), .peripheral_master_irq_en_in(mst), .periph_req_out(req_small),
      .periph_irq_out());
   // ==================================================
   // Bus and compare tasks
   task automatic cmp(input logic [7:0] got, input logic [7:0] exp);
      samples_checked++;
      if (got !== exp) begin
         n_mismatch++;
         $display("ERROR %0t got %h exp %h", $time, got, exp);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk_in);
      addr_in <= a;
      wdata_in <= d;
      wr_in <= 1'b1;
      @(posedge clk_in);
      wr_in <= 1'b0;
   endtask
   task automatic rd(input logic [7:0] a, input logic [7:0] exp);
      @(posedge clk_in);
      addr_in <= a;
      rd_in <= 1'b1;
      @(posedge clk_in);
      rd_in <= 1'b0;
      #1 cmp(rdata_out, exp);
   endtask
   task automatic pulse(input bit b3, input int i);
      @(posedge clk_in);
      if (b3) ev3 <= 8'h01 << i; else ev2 <= 8'h01 << i;
      @(posedge clk_in);
      ev2 <= 8'h00;
      ev3 <= 8'h00;
      #1;
   endtask
   // ==================================================
   // Scenarios
   task automatic t_regs();
      rd(`PIE_OFF_ENABLE_TWO, 8'h00);
      rd(`PIE_OFF_ENABLE_THREE, 8'h00);
      wr(`PIE_OFF_ENABLE_TWO, 8'hFF);
      wr(`PIE_OFF_ENABLE_THREE, 8'hFF);
      wr(8'h07, 8'hFF);
      rd(`PIE_OFF_ENABLE_TWO, 8'hF9);
      cmp(rdata_small, 8'hB9);
      rd(`PIE_OFF_ENABLE_THREE, 8'h3A);
      rd(8'h07, 8'h00);
      wr(`PIE_OFF_ENABLE_THREE, 8'hC5);
      rd(`PIE_OFF_ENABLE_THREE, 8'h00);
      $display("test regs done");
   endtask
   task automatic t_bits();
      logic [7:0] m, ms, bv, eo, fo;
      for (int b = 0; b < 16; b++) begin
         m = (b < 8) ? `PIE_IMPL_TWO_LARGE : `PIE_IMPL_THREE;
         ms = (b < 8) ? `PIE_IMPL_TWO_SMALL : `PIE_IMPL_THREE;
         bv = 8'h01 << (b % 8);
         eo = (b < 8) ? `PIE_OFF_ENABLE_TWO : `PIE_OFF_ENABLE_THREE;
         fo = eo + 8'h02;
         wr(fo, 8'hFF);
         mst <= 1'b0;
         wr(eo, 8'h00);
         pulse(b >= 8, b % 8);
         cmp({6'h00, irq, req}, 8'h00);
         rd(fo, bv & m);
         cmp(rdata_small, bv & ms);
         wr(eo, bv);
         #1 cmp({6'h00, irq, req}, {7'h00, |(bv & m)});
         cmp({7'h00, req_small}, {7'h00, |(bv & ms)});
         @(posedge clk_in);
         mst <= 1'b1;
         #1 cmp({6'h00, irq, req}, {6'h00, |(bv & m), |(bv & m)});
         rd(`PIE_OFF_STATUS, {5'h00, 1'b1, |(bv & m), |(bv & m)});
         wr(fo, bv);
         #1 cmp({6'h00, irq, req}, 8'h00);
      end
      $display("test bits done");
   endtask
   task automatic t_set_wins();
      wr(`PIE_OFF_ENABLE_TWO, 8'h80);
      @(posedge clk_in);
      addr_in <= `PIE_OFF_FLAGS_TWO;
      wdata_in <= 8'h80;
      wr_in <= 1'b1;
      ev2 <= 8'h80;
      @(posedge clk_in);
      wr_in <= 1'b0;
      ev2 <= 8'h00;
      #1 cmp({6'h00, irq, req}, 8'h03);
      rd(`PIE_OFF_FLAGS_TWO, 8'h80);
      $display("test set wins done");
   endtask
   task automatic t_reset_mid();
      wr(`PIE_OFF_ENABLE_TWO, 8'hFF);
      pulse(1'b0, 7);
      cmp({6'h00, irq, req}, 8'h03);
      @(posedge clk_in);
      resetn_in <= 1'b0;
      #1 cmp({6'h00, irq, req}, 8'h00);
      @(posedge clk_in);
      resetn_in <= 1'b1;
      rd(`PIE_OFF_ENABLE_TWO, 8'h00);
      rd(`PIE_OFF_FLAGS_TWO, 8'h00);
      $display("test reset done");
   endtask
   task automatic report_and_stop();
      $display("checked %0d mismatches %0d", samples_checked, n_mismatch);
      if (n_mismatch == 0 && samples_checked > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask
   initial begin
      repeat (5) @(posedge clk_in);
      resetn_in <= 1'b1;
      t_regs();
      t_bits();
      t_set_wins();
      t_reset_mid();
      report_and_stop();
   end
   // Run needs well under 1000 cycles
   always @(posedge clk_in) begin
      cycles <= cycles + 1;
      if (cycles == 3000) begin
         n_mismatch++;
         report_and_stop();
      end
   end
endmodule // pie_enable_banks_bench
`default_nettype wire
